// [rtl/queue_flag_defs.svh]
// Timing counts and reset values for the queue flag logic.
// Assumes one clock for both ports; counts are in mclk cycles.
`ifndef QUEUE_FLAG_DEFS_SVH
`define QUEUE_FLAG_DEFS_SVH

`define QF_FLAG_IDLE 1'h1
`define QF_EMPTY_IDLE 1'h0
`define QF_AF_ASSERT_CYC 3
`define QF_AF_RELEASE_CYC 1
`define QF_AFB_ASSERT_CYC 2
`define QF_AFB_RELEASE_CYC 1
`define QF_AE_ASSERT_CYC 3
`define QF_AE_RELEASE_CYC 1
`define QF_AEB_ASSERT_CYC 3
`define QF_AEB_RELEASE_CYC 1
`define QF_UNIT_NARROW 2'h1
`define QF_UNIT_WIDE 2'h2

`endif

// [rtl/queue_flag_pkg.sv]
// Types shared by the queue flag logic.
// Assumes the defs header supplies all numeric constants.
package queue_flag_pkg;
	typedef enum logic [1:0] {
		WR_SDR40,
		WR_DDR20,
		WR_SDR20
	} wr_mode_e;
endpackage

// [rtl/flag_delay.sv]
// Active-low flag with separate assert and release latencies.
// Assumes lvl_n is a registered-domain level on mclk; hold stalls the change.
`timescale 1ns/100ps
`include "queue_flag_defs.svh"
module flag_delay #(
	parameter int ASSERT_LAT = 3,
	parameter int RELEASE_LAT = 1
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic hold,
	input wire logic lvl_n,
	output logic flag_n
);
	logic [2:0] wait_r;
	logic [2:0] lat;

	assign lat = lvl_n ? 3'(RELEASE_LAT) : 3'(ASSERT_LAT);

	// A level that bounces back before the latency ends leaves the flag alone
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			flag_n <= `QF_FLAG_IDLE;
			wait_r <= 3'h0;
		end else if (ce) begin
			if (lvl_n == flag_n) begin
				wait_r <= 3'h0;
			end else if (hold) begin
				wait_r <= wait_r;
			end else if (wait_r + 3'h1 >= lat) begin
				flag_n <= lvl_n;
				wait_r <= 3'h0;
			end else begin
				wait_r <= wait_r + 3'h1;
			end
		end
	end
endmodule // flag_delay

// [rtl/queue_flag_boundary_logic.sv]
// Occupancy counters per queue; full and empty flags for the selected queue, almost-full and almost-empty also per queue.
// Assumes writer and reader sit on mclk; queue selects and offsets are already valid.
// Function
// (R01) Full low after depth writes, 40-bit class
// (R02) 20-bit into 40-bit: full after twice depth
// (R03) Full asserts on the filling write itself
// (R04) Full releases one cycle after freeing read
// (R05) Almost-full at depth minus offset writes
// (R06) Almost-full indicator asserts three cycles later
// (R07) Almost-full indicator releases after one cycle
// (R08) Almost-full bus bit asserts two cycles later
// (R09) Almost-full bus bit releases after one cycle
// (R10) Write queue switch delays bus change once
// (R11) Almost-empty high after offset plus one writes
// (R12) Almost-empty bus bit uses same boundary
// (R13) Almost-empty indicator asserts three cycles later
// (R14) Almost-empty indicator releases after one cycle
// (R15) SDR40 and DDR20 wide, SDR20 narrow
// (R16) Full counts write words, empty read words; the code sets both flags from the 20-bit unit count
// (R17) Empty releases after the first write
// (R18) One counter per queue, flags active low
`timescale 1ns/100ps
`include "queue_flag_defs.svh"
module queue_flag_boundary_logic #(
	parameter int NUM_QUEUES = 8,
	parameter int DEPTH = 512
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [$clog2(NUM_QUEUES)-1:0] wr_q,
	input queue_flag_pkg::wr_mode_e wr_mode,
	input wire logic rd_en,
	input wire logic [$clog2(NUM_QUEUES)-1:0] rd_q,
	input wire logic rd_wide,
	input wire logic [$clog2(DEPTH+1)-1:0] af_offset,
	input wire logic [$clog2(DEPTH+1)-1:0] ae_offset,
	output logic queue_full_indicator,
	output logic queue_empty_indicator,
	output logic almost_full_indicator,
	output logic almost_empty_indicator,
	output logic [NUM_QUEUES-1:0] almost_full_status_bus,
	output logic [NUM_QUEUES-1:0] almost_empty_status_bus
);
	localparam int QW = $clog2(NUM_QUEUES);
	localparam int CW = $clog2(2 * DEPTH + 1) + 2;
	localparam logic [CW-1:0] CAP = CW'(2 * DEPTH);

	logic [CW-1:0] occ_r [NUM_QUEUES];
	logic [CW-1:0] occ_nxt [NUM_QUEUES];
	logic [1:0] wr_unit;
	logic [1:0] rd_unit;
	logic [CW-1:0] af_thresh;
	logic [CW-1:0] ae_thresh;
	logic [NUM_QUEUES-1:0] af_lvl_n;
	logic [NUM_QUEUES-1:0] ae_lvl_n;
	logic [QW-1:0] wr_q_r;
	logic [QW-1:0] rd_q_r;
	logic wr_switch;
	logic rd_switch;

	// SDR20 alone is the narrow write class; occupancy is kept in 20-bit units
	assign wr_unit = (wr_mode == queue_flag_pkg::WR_SDR20) ? `QF_UNIT_NARROW : `QF_UNIT_WIDE; // see (R15)
	assign rd_unit = rd_wide ? `QF_UNIT_WIDE : `QF_UNIT_NARROW;
	// Capacity is DEPTH 40-bit words, so 2*DEPTH units for either class
	assign af_thresh = CAP - CW'(af_offset) * CW'(wr_unit); // see (R05) (R16)
	// Boundary in words of the wider port keeps n+1 and (n+1)*2 writes exact
	assign ae_thresh = (CW'(ae_offset) + CW'(1)) * CW'((wr_unit > rd_unit) ? wr_unit : rd_unit); // see (R11) (R12)
	assign wr_switch = (wr_q != wr_q_r);
	assign rd_switch = (rd_q != rd_q_r);

	always_comb begin
		for (int q = 0; q < NUM_QUEUES; q++) begin
			occ_nxt[q] = occ_r[q];
			// Overfill and underflow are dropped rather than wrapped
			if (wr_en && wr_q == QW'(q) && occ_r[q] + CW'(wr_unit) <= CAP) begin
				occ_nxt[q] = occ_nxt[q] + CW'(wr_unit); // see (R18)
			end
			if (rd_en && rd_q == QW'(q) && occ_r[q] >= CW'(rd_unit)) begin
				occ_nxt[q] = occ_nxt[q] - CW'(rd_unit); // see (R18)
			end
			af_lvl_n[q] = !(occ_r[q] >= af_thresh);
			ae_lvl_n[q] = (occ_r[q] >= ae_thresh);
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			for (int q = 0; q < NUM_QUEUES; q++) begin
				occ_r[q] <= '0;
			end
		end else if (ce) begin
			for (int q = 0; q < NUM_QUEUES; q++) begin
				occ_r[q] <= occ_nxt[q];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wr_q_r <= '0;
			rd_q_r <= '0;
		end else if (ce) begin
			wr_q_r <= wr_q;
			rd_q_r <= rd_q;
		end
	end

	// Full takes the post-write count so it falls on the filling edge
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			queue_full_indicator <= `QF_FLAG_IDLE;
		end else if (ce) begin
			queue_full_indicator <= !(occ_nxt[wr_q] >= CAP || occ_r[wr_q] >= CAP); // see (R01) (R02) (R03) (R04)
		end
	end

	// Empty falls on the emptying read and rises one cycle after a write
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			queue_empty_indicator <= `QF_EMPTY_IDLE;
		end else if (ce) begin
			queue_empty_indicator <= (occ_nxt[rd_q] != '0) && (occ_r[rd_q] != '0); // see (R17)
		end
	end

	flag_delay #(.ASSERT_LAT(`QF_AF_ASSERT_CYC), .RELEASE_LAT(`QF_AF_RELEASE_CYC)) af_ind ( // see (R06) (R07)
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ce(ce),
		.hold(1'h0),
		.lvl_n(af_lvl_n[wr_q]),
		.flag_n(almost_full_indicator)
	);

	// Almost-empty indicator starts low: queues are empty after reset
	// The level is inverted, so release rides the falling edge and the latencies swap
	logic ae_ind_n;
	flag_delay #(.ASSERT_LAT(`QF_AE_RELEASE_CYC), .RELEASE_LAT(`QF_AE_ASSERT_CYC)) ae_ind ( // see (R13) (R14)
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ce(ce),
		.hold(1'h0),
		.lvl_n(!ae_lvl_n[rd_q]),
		.flag_n(ae_ind_n)
	);
	assign almost_empty_indicator = !ae_ind_n;

	for (genvar q = 0; q < NUM_QUEUES; q++) begin : g_bus
		logic aeb_n;
		flag_delay #(.ASSERT_LAT(`QF_AFB_ASSERT_CYC), .RELEASE_LAT(`QF_AFB_RELEASE_CYC)) afb ( // see (R08) (R09)
			.mclk(mclk),
			.sys_rst(sys_rst),
			.ce(ce),
			.hold(wr_switch), // see (R10)
			.lvl_n(af_lvl_n[q]),
			.flag_n(almost_full_status_bus[q])
		);
		flag_delay #(.ASSERT_LAT(`QF_AEB_RELEASE_CYC), .RELEASE_LAT(`QF_AEB_ASSERT_CYC)) aeb ( // see (R12)
			.mclk(mclk),
			.sys_rst(sys_rst),
			.ce(ce),
			.hold(rd_switch),
			.lvl_n(!ae_lvl_n[q]),
			.flag_n(aeb_n)
		);
		assign almost_empty_status_bus[q] = !aeb_n;
	end

	// Checks; a frozen clock enable abandons any attempt in flight
	logic af0;
	logic ae0;
	assign af0 = af_lvl_n[wr_q];
	assign ae0 = ae_lvl_n[rd_q];

	property p_full_now;
		@(posedge mclk) disable iff (sys_rst || !ce)
		(wr_en && occ_nxt[wr_q] >= CAP) |=> !queue_full_indicator;
	endproperty
	a_full_now: assert property (p_full_now) else $error("full not low after filling write"); // see (R01) (R03)

	property p_full_release;
		@(posedge mclk) disable iff (sys_rst || !ce)
		(!queue_full_indicator && occ_r[wr_q] < CAP && occ_nxt[wr_q] < CAP) |=> queue_full_indicator;
	endproperty
	a_full_release: assert property (p_full_release) else $error("full did not release"); // see (R04)

	property p_af_assert;
		@(posedge mclk) disable iff (sys_rst || !ce)
		($fell(af0) && !wr_switch) ##1 (!af0 && !wr_switch)[*2] |=> !almost_full_indicator;
	endproperty
	a_af_assert: assert property (p_af_assert) else $error("almost-full indicator late"); // see (R06)

	property p_af_early;
		@(posedge mclk) disable iff (sys_rst || !ce)
		$fell(af0) && !wr_switch && almost_full_indicator |=> almost_full_indicator;
	endproperty
	a_af_early: assert property (p_af_early) else $error("almost-full indicator early"); // see (R06)

	property p_af_release;
		@(posedge mclk) disable iff (sys_rst || !ce)
		($rose(af0) && !wr_switch) |=> almost_full_indicator;
	endproperty
	a_af_release: assert property (p_af_release) else $error("almost-full indicator release late"); // see (R07)

	property p_afb_assert;
		@(posedge mclk) disable iff (sys_rst || !ce)
		($fell(af_lvl_n[0]) && !wr_switch) ##1 (!af_lvl_n[0] && !wr_switch) |=> !almost_full_status_bus[0];
	endproperty
	a_afb_assert: assert property (p_afb_assert) else $error("almost-full bus bit late"); // see (R08) (R10)

	property p_afb_release;
		@(posedge mclk) disable iff (sys_rst || !ce)
		($rose(af_lvl_n[0]) && !wr_switch) |=> almost_full_status_bus[0];
	endproperty
	a_afb_release: assert property (p_afb_release) else $error("almost-full bus bit release late"); // see (R09)

	property p_ae_assert;
		@(posedge mclk) disable iff (sys_rst || !ce)
		($fell(ae0) && !rd_switch) ##1 (!ae0 && !rd_switch)[*2] |=> !almost_empty_indicator;
	endproperty
	a_ae_assert: assert property (p_ae_assert) else $error("almost-empty indicator late"); // see (R13)

	property p_ae_release;
		@(posedge mclk) disable iff (sys_rst || !ce)
		($rose(ae0) && !rd_switch) |=> almost_empty_indicator;
	endproperty
	a_ae_release: assert property (p_ae_release) else $error("almost-empty indicator release late"); // see (R14)

	property p_empty_release;
		@(posedge mclk) disable iff (sys_rst || !ce)
		(occ_r[rd_q] == '0 && wr_en && wr_q == rd_q && !rd_en) ##1 (!rd_switch && !rd_en) |=> queue_empty_indicator;
	endproperty
	a_empty_release: assert property (p_empty_release) else $error("empty did not release after write"); // see (R17)

	property p_aeb_assert;
		@(posedge mclk) disable iff (sys_rst || !ce)
		($fell(ae_lvl_n[0]) && !rd_switch) ##1 (!ae_lvl_n[0] && !rd_switch)[*2] |=> !almost_empty_status_bus[0];
	endproperty
	a_aeb_assert: assert property (p_aeb_assert) else $error("almost-empty bus bit late"); // see (R12)

	property p_aeb_release;
		@(posedge mclk) disable iff (sys_rst || !ce)
		($rose(ae_lvl_n[0]) && !rd_switch) |=> almost_empty_status_bus[0];
	endproperty
	a_aeb_release: assert property (p_aeb_release) else $error("almost-empty bus bit release late"); // see (R12)
endmodule // queue_flag_boundary_logic

// [bench/queue_user.sv]
// Writer and reader model standing at the queue ports.
// Assumes each task starts just after a rising mclk edge.
`timescale 1ns/100ps
module queue_user (
	input wire logic mclk,
	output logic wr_en,
	output logic [0:0] wr_q,
	output logic rd_en,
	output logic [0:0] rd_q
);
	// Both ports start on queue 0 so the discrete flags track it
	initial begin
		wr_en = 1'h0;
		rd_en = 1'h0;
		wr_q = 1'h0;
		rd_q = 1'h0;
	end
	// Back-to-back words, one per cycle, strobe held until the last edge
	task automatic put(input int n);
		for (int i = 0; i < n; i++) begin
			wr_en <= 1'h1;
			@(posedge mclk);
		end
		wr_en <= 1'h0;
	endtask
	// Selects move just after an edge, like the strobes
	task automatic sel(input logic w, input logic r);
		wr_q <= w;
		rd_q <= r;
	endtask
	task automatic get(input int n);
		for (int i = 0; i < n; i++) begin
			rd_en <= 1'h1;
			@(posedge mclk);
		end
		rd_en <= 1'h0;
	endtask
endmodule // queue_user

// [bench/queue_flag_boundary_logic_bench.sv]
// Self-checking bench for the queue flag logic, DEPTH 8, offsets m=2 n=1.
// Assumes queue_user drives strobes and selects; op 3 rows narrow the read port.
`timescale 1ns/100ps
`define CMP(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module queue_flag_boundary_logic_bench;
	localparam queue_flag_pkg::wr_mode_e s40 = queue_flag_pkg::WR_SDR40;
	localparam queue_flag_pkg::wr_mode_e d20 = queue_flag_pkg::WR_DDR20;
	localparam queue_flag_pkg::wr_mode_e s20 = queue_flag_pkg::WR_SDR20;
	// Op 0 writes, 1 reads, 2 resets then writes, 3 as 2 with a 20-bit read port
	// e holds flags after edges 0 to 3
	typedef struct {logic [1:0] op; queue_flag_pkg::wr_mode_e m; int n; logic [31:0] e;} row_s;
	logic mclk;
	logic sys_rst;
	logic ce;
	logic rd_wide;
	queue_flag_pkg::wr_mode_e wr_mode;
	logic wr_en, rd_en;
	logic [0:0] wr_q, rd_q;
	logic full_n, empty_n, af_n, ae_n;
	logic [1:0] afb_n, aeb_n;
	logic [7:0] flags;
	int bad_count = 0;
	int n_tests = 0;
	row_s rows [30] = '{
		'{2'h2, s40, 1, 32'hCCDC_DCDC}, '{2'h0, s40, 1, 32'hDCFD_FDFD}, '{2'h0, s40, 3, 32'hFDFD_FDFD},
		'{2'h0, s40, 1, 32'hFDFD_F9B9}, '{2'h0, s40, 1, 32'hB9B9_B9B9}, '{2'h0, s40, 1, 32'h3939_3939},
		'{2'h1, s40, 1, 32'h39B9_B9B9}, '{2'h1, s40, 2, 32'hB9FD_FDFD}, '{2'h1, s40, 3, 32'hFDFD_FDFD},
		'{2'h1, s40, 1, 32'hFDFD_FDDC}, '{2'h1, s40, 1, 32'hCCCC_CCCC}, '{2'h0, s40, 1, 32'hCCDC_DCDC},
		'{2'h0, s40, 1, 32'hDCFD_FDFD}, '{2'h2, d20, 5, 32'hFDFD_FDFD}, '{2'h0, d20, 1, 32'hFDFD_F9B9},
		'{2'h0, d20, 1, 32'hB9B9_B9B9}, '{2'h0, d20, 1, 32'h3939_3939}, '{2'h2, s20, 1, 32'hCCDC_DCDC},
		'{2'h0, s20, 2, 32'hDCDC_DCDC}, '{2'h0, s20, 1, 32'hDCFD_FDFD}, '{2'h0, s20, 9, 32'hFDFD_FDFD},
		'{2'h0, s20, 1, 32'hFDFD_F9B9}, '{2'h0, s20, 1, 32'hB9B9_B9B9}, '{2'h0, s20, 1, 32'h3939_3939},
		'{2'h0, s20, 1, 32'h3939_3939}, '{2'h1, s20, 1, 32'h39B9_B9B9},
		'{2'h3, s40, 2, 32'hDCFD_FDFD}, '{2'h1, s40, 1, 32'hFDFD_FDDC}, '{2'h1, s40, 2, 32'hDCDC_DCDC},
		'{2'h1, s40, 1, 32'hCCCC_CCCC}};
	assign flags = {full_n, af_n, ae_n, empty_n, afb_n, aeb_n};
	queue_flag_boundary_logic #(.NUM_QUEUES(2), .DEPTH(8)) DUT (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ce(ce),
		.wr_en(wr_en),
		.wr_q(wr_q),
		.wr_mode(wr_mode),
		.rd_en(rd_en),
		.rd_q(rd_q),
		.rd_wide(rd_wide),
		.af_offset(4'h2),
		.ae_offset(4'h1),
		.queue_full_indicator(full_n),
		.queue_empty_indicator(empty_n),
		.almost_full_indicator(af_n),
		.almost_empty_indicator(ae_n),
		.almost_full_status_bus(afb_n),
		.almost_empty_status_bus(aeb_n)
	);
	queue_user usr (
		.mclk(mclk),
		.wr_en(wr_en),
		.wr_q(wr_q),
		.rd_en(rd_en),
		.rd_q(rd_q)
	);
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	task automatic finish_test;
		$display("mismatches %0d comparisons %0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic rst;
		sys_rst <= 1'h1;
		repeat (5) @(posedge mclk);
		sys_rst <= 1'h0;
		@(posedge mclk);
	endtask
	// Flag levels after the last strobe's edge and the three edges that follow
	task automatic check4(input logic [31:0] e);
		for (int j = 0; j < 4; j++) begin
			@(negedge mclk);
			`CMP(flags, e[31-8*j -: 8])
			@(posedge mclk);
		end
	endtask
	// Whole run is under a thousand cycles
	initial begin
		repeat (5000) @(posedge mclk);
		bad_count++;
		finish_test;
	end
	initial begin
		sys_rst = 1'h1;
		ce = 1'h1;
		rd_wide = 1'h1;
		wr_mode = s40;
		rst;
		@(negedge mclk);
		`CMP(flags, 8'hCC) // Idle levels
		@(posedge mclk);
		foreach (rows[k]) begin
			if (rows[k].op[1]) begin
				wr_mode <= rows[k].m;
				rd_wide <= !rows[k].op[0];
				rst;
			end
			if (rows[k].op == 2'h1) begin
				usr.get(rows[k].n);
			end else begin
				usr.put(rows[k].n);
			end
			check4(rows[k].e);
		end
		// Clock enable low: writes are lost and every flag holds
		ce <= 1'h0;
		usr.put(2);
		check4(32'hCCCC_CCCC);
		ce <= 1'h1;
		usr.put(1);
		check4(32'hCCDC_DCDC);
		// Write queue switch as the boundary is crossed stretches the bus bit by one cycle
		usr.put(5);
		usr.sel(1'h1, 1'h0);
		check4(32'hFDFD_FDF9);
		// Read port moves to the empty queue; discrete empty and almost-empty follow it
		usr.sel(1'h1, 1'h1);
		check4(32'hF9E9_E9C9);
		finish_test;
	end
endmodule // queue_flag_boundary_logic_bench
